// >>> design/isf_pkg.sv
// Package: status word layout, command codes and carriers for the status flag block
package isf_pkg;
  localparam int ISF_W = 16;
  localparam logic [7:0] ISF_REG_MAIN = 8'h03;
  localparam logic [7:0] ISF_REG_SECOND = 8'hEC;
  localparam logic [15:0] ISF_MAIN_LATCH = 16'h7F01;
  localparam logic [15:0] ISF_SECOND_LATCH = 16'h03D6;
  localparam logic [15:0] ISF_USED_MASK = 16'h7FFF;
  localparam logic [15:0] ISF_ZERO16 = 16'h0000;
  localparam logic [15:0] ISF_MASK_RESET = 16'h0000;
  localparam int ISF_DIGITS = 5;
  localparam logic [3:0] ISF_TEN = 4'hA;
  localparam logic [2:0] ISF_LAST_DIGIT = 3'h4;

  // Host command codes
  typedef enum logic [2:0] {
    ISF_CMD_NONE = 3'h0,
    ISF_CMD_READ = 3'h1,
    ISF_CMD_CLEAR = 3'h2,
    ISF_CMD_CHECK = 3'h3,
    ISF_CMD_REG = 3'h4
  } isf_cmd_t;

  // Event pulses and live levels from the servo core
  typedef struct packed {
    logic lowVolt;
    logic overVolt;
    logic waitExpired;
    logic stopInputFound;
    logic moveStart;
    logic haltReceived;
    logic holdErr;
    logic moveErr;
    logic indexFound;
  } isf_evt_t;

  typedef struct packed {
    logic overTemp;
    logic largeFrame;
    logic driveDisable;
    logic [2:0] ioLines;
    logic calcNeg;
    logic calcPos;
    logic calcZero;
  } isf_live_t;

  typedef struct packed {
    isf_cmd_t cmd;
    logic [7:0] regNum;
    logic [15:0] arg;
  } isf_req_t;

  typedef enum logic [2:0] {
    ISF_IDLE = 3'b001,
    ISF_CONV = 3'b010,
    ISF_SEND = 3'b100
  } isf_state_t;
endpackage

// >>> design/isf_dec_digit.sv
// Divider step: one decimal digit off a binary word, registered
`timescale 1ns/1ps
module isf_dec_digit
  import isf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [15:0] value,
  output logic [15:0] quotient_r,
  output logic [3:0] digit_r
);
  logic [15:0] quotNxt;
  logic [3:0] digitNxt;
  assign quotNxt = value / 16'(ISF_TEN);
  assign digitNxt = 4'(value % 16'(ISF_TEN));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      quotient_r <= ISF_ZERO16;
      digit_r <= 4'h0;
    end else if (load) begin
      quotient_r <= quotNxt;
      digit_r <= digitNxt;
    end
  end
endmodule

// >>> design/isf_status_flags.sv
// Internal status word: latched events, live bits, check mask and host access
`timescale 1ns/1ps
module isf_status_flags
  import isf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input isf_evt_t evt,
  input isf_live_t liveRaw,
  input wire logic [15:0] secondEvt,
  input wire logic [15:0] secondLive,
  input isf_req_t req,
  input wire logic reqValid,
  output logic reqReady,
  output logic [31:0] regData_r,
  output logic regDataValid_r,
  output logic [3:0] decDigit_r,
  output logic decDigitValid_r,
  output logic decLast_r,
  output logic [15:0] statusWord,
  output logic [15:0] checkMask_r,
  output logic pollCheckBit
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for live levels
  // Two flops keep metastable pin levels out of the status word
  isf_live_t liveMeta_r;
  isf_live_t live_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      liveMeta_r <= '0;
      live_r <= '0;
    end else begin
      liveMeta_r <= liveRaw;
      live_r <= liveMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched flags
  logic [15:0] latch_r;
  logic [15:0] latchSet;
  logic [15:0] second_r;
  logic [15:0] liveWord;
  logic [15:0] fullWord;
  logic [15:0] secondWord;
  logic take;
  logic clearCmd;
  logic takeCheck;
  logic takeReg;
  logic takeRead;
  logic bit7;
  logic [15:0] mainClr;
  logic [15:0] autoClr;
  logic [15:0] latchNxt;
  logic [15:0] secondClr;
  logic [15:0] secondNxt;

  // Named set strobes, one per latched flag
  logic setLowVolt;
  logic setOverVolt;
  logic setWait;
  logic setStop;
  logic setHalt;
  logic setHold;
  logic setMove;
  logic setIndex;

  // Live fields of the word
  logic [2:0] ioWord;
  logic [2:0] calcWord;
  logic tempOk;
  logic driveOff;
  logic largeFrame;
  logic [15:0] secondLiveBits;
  logic [15:0] checkMaskNxt;
  logic [15:0] pollHits;
  logic regIsMain;
  logic regIsSecond;

  // Command strobe decode, shared by every command path
  function automatic logic cmdTaken(input logic strobe, input isf_cmd_t have, input isf_cmd_t want);
    return strobe && (have == want);
  endfunction

  // Host port: a command is taken on the edge where valid meets ready
  assign take = reqValid && reqReady;
  assign clearCmd = cmdTaken(take, req.cmd, ISF_CMD_CLEAR);
  assign takeCheck = cmdTaken(take, req.cmd, ISF_CMD_CHECK);
  assign takeReg = cmdTaken(take, req.cmd, ISF_CMD_REG);
  assign takeRead = cmdTaken(take, req.cmd, ISF_CMD_READ);

  // Event pulses land in named set strobes
  assign setLowVolt = evt.lowVolt;
  assign setOverVolt = evt.overVolt;
  assign setWait = evt.waitExpired;
  assign setStop = evt.stopInputFound;
  assign setHalt = evt.haltReceived;
  assign setHold = evt.holdErr;
  assign setMove = evt.moveErr;
  assign setIndex = evt.indexFound;

  // Set strobes ordered by bit position
  assign latchSet = {1'b0,
    setLowVolt,
    setOverVolt,
    setWait,
    setStop,
    setHalt,
    setHold,
    setMove,
    7'h00,
    setIndex};

  // Clear-status wipes every latched bit; a move start wipes bit 11 only
  assign mainClr = clearCmd ? ISF_MAIN_LATCH : ISF_ZERO16;
  assign autoClr = {4'h0, evt.moveStart, 11'h000};
  // Set wins over clear when both fall in one cycle
  assign latchNxt = ((latch_r & ~mainClr & ~autoClr) | latchSet) & ISF_MAIN_LATCH;
  assign secondClr = clearCmd ? ISF_SECOND_LATCH : ISF_ZERO16;
  assign secondNxt = ((second_r & ~secondClr) | secondEvt) & ISF_SECOND_LATCH;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= ISF_ZERO16;
    end else begin
      latch_r <= latchNxt;
    end
  end

  // Second word latches follow the same set-wins rule
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      second_r <= ISF_ZERO16;
    end else begin
      second_r <= secondNxt;
    end
  end

  // Bit 7 is active low for temperature; the large frame shows the drive disable line there
  assign tempOk = ~live_r.overTemp;
  assign driveOff = live_r.driveDisable;
  assign largeFrame = live_r.largeFrame;
  assign bit7 = largeFrame ? driveOff : tempOk;
  assign ioWord = live_r.ioLines;
  assign calcWord = {live_r.calcNeg, live_r.calcPos, live_r.calcZero};
  assign liveWord = {8'h00, bit7, ioWord, calcWord, 1'b0};
  assign fullWord = (latch_r | liveWord) & ISF_USED_MASK;
  // Second word: latched bits from second_r, the rest pass through live
  assign secondLiveBits = secondLive & ~ISF_SECOND_LATCH;
  assign secondWord = second_r | secondLiveBits;
  assign statusWord = fullWord;

  ////////////////////////////////////////////////////////////////////////////
  // Check mask and polling bit
  // The mask is written whole; bit 15 never takes a one
  assign checkMaskNxt = req.arg & ISF_USED_MASK;
  assign pollHits = fullWord & checkMask_r & ISF_USED_MASK;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      checkMask_r <= ISF_MASK_RESET;
    end else if (takeCheck) begin
      checkMask_r <= checkMaskNxt;
    end
  end

  assign pollCheckBit = |pollHits;

  ////////////////////////////////////////////////////////////////////////////
  // Register read
  // Unknown register numbers read back as zero
  assign regIsMain = (req.regNum == ISF_REG_MAIN);
  assign regIsSecond = (req.regNum == ISF_REG_SECOND);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regData_r <= 32'h00000000;
      regDataValid_r <= 1'b0;
    end else begin
      regDataValid_r <= takeReg;
      if (takeReg) begin
        if (regIsMain) begin
          regData_r <= {fullWord, ISF_ZERO16};
        end else if (regIsSecond) begin
          regData_r <= {secondWord, ISF_ZERO16};
        end else begin
          regData_r <= 32'h00000000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decimal read-out, least significant digit first
  // Each digit takes two cycles: the divider loads in one, the digit is
  // registered out in the next. The host port stays busy for the whole
  // read-out so the running quotient cannot be disturbed.
  isf_state_t state_r;
  isf_state_t stateNxt;
  logic [2:0] digitCnt_r;
  logic [15:0] work_r;
  logic [15:0] quot;
  logic [3:0] digit;
  logic stepLoad;
  logic inIdle;
  logic inConv;
  logic inSend;
  logic lastDigit;
  logic [15:0] convSource;

  assign inIdle = (state_r == ISF_IDLE);
  assign inConv = (state_r == ISF_CONV);
  assign inSend = (state_r == ISF_SEND);
  assign lastDigit = (digitCnt_r == ISF_LAST_DIGIT);
  assign reqReady = inIdle;
  assign stepLoad = (inIdle && takeRead) || inSend;
  // First digit comes off the full status word (latched and live bits), later ones off the running quotient
  assign convSource = inIdle ? fullWord : work_r;

  isf_dec_digit uDigit (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(stepLoad),
    .value(convSource),
    .quotient_r(quot),
    .digit_r(digit)
  );

  always_comb begin
    stateNxt = state_r;
    case (state_r)
      ISF_IDLE: begin
        if (takeRead) begin
          stateNxt = ISF_CONV;
        end
      end
      ISF_CONV: begin
        stateNxt = ISF_SEND;
      end
      ISF_SEND: begin
        stateNxt = lastDigit ? ISF_IDLE : ISF_CONV;
      end
      default: begin
        stateNxt = ISF_IDLE;
      end
    endcase
  end

  // Digit counter steps once per digit, on the send cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ISF_IDLE;
      digitCnt_r <= 3'h0;
    end else begin
      state_r <= stateNxt;
      if (inIdle) begin
        digitCnt_r <= 3'h0;
      end else if (inSend) begin
        digitCnt_r <= digitCnt_r + 3'h1;
      end
    end
  end

  // Digit and last-digit outputs hold until the next digit replaces them; the valid output is high for one cycle per digit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      work_r <= ISF_ZERO16;
      decDigit_r <= 4'h0;
      decDigitValid_r <= 1'b0;
      decLast_r <= 1'b0;
    end else begin
      decDigitValid_r <= inConv;
      if (inConv) begin
        decDigit_r <= digit;
        decLast_r <= lastDigit;
        work_r <= quot;
      end
    end
  end
endmodule

// >>> verif/isf_status_flags_sva.sv
// Checker: assertions on the status flag block ports
`timescale 1ns/1ps
module isf_status_flags_sva
  import isf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input isf_evt_t evt,
  input isf_req_t req,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic [31:0] regData_r,
  input wire logic regDataValid_r,
  input wire logic decDigitValid_r,
  input wire logic [15:0] statusWord,
  input wire logic [15:0] checkMask_r,
  input wire logic pollCheckBit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire tk = reqValid && reqReady;
  low_volt_a: assert property (evt.lowVolt |=> statusWord[14])
    else $error("bit 14 not set");
  move_clear_a: assert property (evt.moveStart && !evt.stopInputFound |=> !statusWord[11])
    else $error("bit 11 not cleared");
  flag_hold_a: assert property ($fell(statusWord[14]) |-> $past(tk && req.cmd == ISF_CMD_CLEAR))
    else $error("bit 14 dropped");
  clear_all_a: assert property (tk && req.cmd == ISF_CMD_CLEAR && evt == '0 |=> !(|(statusWord & ISF_MAIN_LATCH)))
    else $error("latched bits kept");
  poll_or_a: assert property (pollCheckBit == |(statusWord & checkMask_r & ISF_USED_MASK))
    else $error("poll bit wrong");
  reserved_a: assert property (!statusWord[15] && !checkMask_r[15])
    else $error("bit 15 set");
  reg_read_a: assert property (tk && req.cmd == ISF_CMD_REG && req.regNum == ISF_REG_MAIN |=>
    regDataValid_r && regData_r == {$past(statusWord), 16'h0000}) else $error("register 3 wrong");
  dec_busy_a: assert property (tk && req.cmd == ISF_CMD_READ |->
    ##2 decDigitValid_r ##1 !reqReady [*8] ##1 reqReady) else $error("read-out timing");
endmodule
bind isf_status_flags isf_status_flags_sva u_sva(.*);

// >>> verif/isf_host_model.sv
// Host model: issues status commands and reacts to the poll bit
`timescale 1ns/1ps
module isf_host_model
  import isf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reqReady,
  input wire logic pollCheckBit,
  output isf_req_t req,
  output logic reqValid
);
  initial begin
    req = '{ISF_CMD_NONE, 8'h00, 16'h0000};
    reqValid = 1'b0;
  end
  task automatic send(input isf_cmd_t c, input logic [7:0] n, input logic [15:0] a);
    @(negedge ref_clk);
    req = '{c, n, a};
    reqValid = 1'b1;
    while (reqReady !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    reqValid = 1'b0;
    req = '{ISF_CMD_NONE, ~n, ~a};
  endtask
  task automatic pollRead();
    if (pollCheckBit === 1'b1) send(ISF_CMD_READ, 8'h00, 16'h0000);
  endtask
endmodule

// >>> verif/test_internal_status_word_flags.sv
// Testbench: random and corner stimulus for the status flag block
`timescale 1ns/1ps
module test_internal_status_word_flags;
  import isf_pkg::*;
  logic ref_clk, rst_n, reqValid, reqReady, regDataValid_r, decDigitValid_r, decLast_r, pollCheckBit;
  isf_evt_t evt;
  isf_live_t liveRaw;
  isf_req_t req;
  logic [15:0] secondEvt, secondLive, statusWord, checkMask_r, lat, sec;
  logic [31:0] regData_r, r;
  logic [3:0] decDigit_r;
  int error_cnt, n_checks, seed;
  int bitPos [9] = '{14, 13, 12, 11, 11, 10, 9, 8, 0};
  isf_status_flags DUT(.*);
  isf_host_model host(.*);
  function automatic logic [15:0] expw();
    logic [15:0] w;
    w = lat;
    w[7] = liveRaw.largeFrame ? liveRaw.driveDisable : ~liveRaw.overTemp;
    w[6:1] = {liveRaw.ioLines, liveRaw.calcNeg, liveRaw.calcPos, liveRaw.calcZero};
    return w;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task regRd(input logic [7:0] n, input logic [31:0] e);
    host.send(ISF_CMD_REG, n, 16'h0000);
    chk(regDataValid_r, 1);
    chk(regData_r, e);
  endtask
  task readDec(input logic [15:0] w);
    int k;
    k = 0;
    host.send(ISF_CMD_READ, 8'h00, 16'h0000);
    repeat (12) begin
      @(posedge ref_clk);
      #1;
      if (decDigitValid_r === 1'b1) begin
        chk(decDigit_r, (w / (10 ** k)) % 10);
        chk(decLast_r, k == 4);
        k++;
      end
    end
    chk(k, 5);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #50000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    seed = 45;
    lat = 16'h0000;
    rst_n = 1'b0;
    evt = '0;
    liveRaw = '0;
    secondEvt = 16'h0000;
    secondLive = 16'h0000;
    cyc(5);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      r[7] = i[0];
      liveRaw = isf_live_t'(r[8:0]);
      cyc(3);
      chk(statusWord, expw());
    end
    for (int i = 0; i < 9; i++) begin
      evt = isf_evt_t'(9'h100 >> i);
      lat[bitPos[i]] = (i != 4);
      cyc(1);
      evt = '0;
      cyc(2);
      chk(statusWord, expw());
    end
    r = $random(seed);
    secondLive = r[15:0];
    secondEvt = 16'hFFFF;
    cyc(1);
    secondEvt = 16'h0000;
    cyc(2);
    sec = secondLive & ~ISF_SECOND_LATCH;
    regRd(8'h03, {expw(), 16'h0000});
    regRd(8'hEC, {sec | ISF_SECOND_LATCH, 16'h0000});
    regRd(8'h55, 32'h0);
    readDec(expw());
    foreach (bitPos[i]) begin
      r = (i < 3) ? 32'h8000 >> (i * 15) : $random(seed);
      host.send(ISF_CMD_CHECK, 8'h00, r[15:0]);
      cyc(1);
      chk(checkMask_r, r[15:0] & 16'h7FFF);
      chk(pollCheckBit, |(expw() & r[14:0]));
    end
    host.pollRead();
    cyc(12);
    host.send(ISF_CMD_CLEAR, 8'h00, 16'h0000);
    cyc(1);
    lat = 16'h0000;
    chk(statusWord, expw());
    regRd(8'hEC, {sec, 16'h0000});
    end_of_test();
  end
endmodule
